// [usart_pkg.sv]
// Shared constants, types and decoding for the serial frame and transmit block
package usart_pkg;

	localparam int          ADDR_W = 8;
	localparam int          DATA_W = 32;

	localparam logic [7:0]  OFF_STATUS = 8'h00;
	localparam logic [7:0]  OFF_CTRL_B = 8'h04;
	localparam logic [7:0]  OFF_CTRL_C = 8'h08;
	localparam logic [7:0]  OFF_DATA   = 8'h0C;
	localparam logic [7:0]  OFF_BAUD   = 8'h10;

	localparam int          ST_RXC  = 7;
	localparam int          ST_TXC  = 6;
	localparam int          ST_DRE  = 5;
	localparam int          ST_FE   = 4;

	localparam int          CB_U2X  = 5;
	localparam int          CB_RXEN = 4;
	localparam int          CB_TXEN = 3;
	localparam int          CB_CSZ2 = 2;
	localparam int          CB_RXB8 = 1;
	localparam int          CB_TXB8 = 0;

	localparam int          CC_MAST = 7;
	localparam int          CC_SYNC = 6;
	localparam int          CC_PAR  = 4;
	localparam int          CC_STOP = 3;
	localparam int          CC_CSZ  = 1;
	localparam int          CC_POL  = 0;

	localparam logic [7:0]  CTRL_B_RST = 8'h00;
	localparam logic [7:0]  CTRL_C_RST = 8'h06;
	localparam logic [11:0] BAUD_RST   = 12'h000;

	localparam logic [3:0]  SPB_NORMAL = 4'hF;
	localparam logic [3:0]  SPB_DOUBLE = 4'h7;
	localparam logic [3:0]  HALF_NORMAL = 4'h7;
	localparam logic [3:0]  HALF_DOUBLE = 4'h3;

	localparam logic [1:0]  PAR_OFF  = 2'h0;
	localparam logic [1:0]  PAR_EVEN = 2'h2;
	localparam logic [1:0]  PAR_ODD  = 2'h3;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP1, TX_STOP2} txState_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rxState_t;

	// Codes 4 to 6 are reserved and fall back to eight bits
	function automatic logic [3:0] dataBits(input logic [2:0] csz);
		unique case (csz)
			3'h0: dataBits = 4'h5;
			3'h1: dataBits = 4'h6;
			3'h2: dataBits = 4'h7;
			3'h7: dataBits = 4'h9;
			default: dataBits = 4'h8;
		endcase
	endfunction

	function automatic logic [8:0] dataMask(input logic [3:0] nBits);
		// One mask bit per data bit, counted from the bottom
		dataMask = 9'h1FF >> (4'h9 - nBits);
	endfunction

endpackage

// [usart_clock_gen.sv]
// Baud divider, transfer clock generation and transfer clock edge detection
`timescale 1ns/1ps
module usart_clock_gen (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [11:0] baudDivisor,
	input  wire logic        baudReload,
	input  wire logic        doubleSpeed,
	input  wire logic        syncMode,
	input  wire logic        syncMaster,
	input  wire logic        clockPolarity,
	input  wire logic        xckPin,
	output logic             txTick,
	output logic             rxOvTick,
	output logic             rxSampleEdge,
	output logic             xckOut
);

	logic [11:0] baudCnt_r;
	logic [3:0]  prescale_r;
	logic        xckInt_r;
	logic        xckS1_r;
	logic        xckS2_r;
	logic        xckS3_r;
	logic        baudTick;
	logic [3:0]  prescaleTop;
	logic        xckRise;
	logic        xckFall;

	assign baudTick    = (baudCnt_r == 12'h000);
	assign prescaleTop = doubleSpeed ? usart_pkg::SPB_DOUBLE : usart_pkg::SPB_NORMAL;

	// Divider reloads on a divisor write, but with the old divisor; the new rate starts at the next reload
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			baudCnt_r <= usart_pkg::BAUD_RST;
		end else if (baudReload || baudTick) begin
			baudCnt_r <= baudDivisor;
		end else begin
			baudCnt_r <= baudCnt_r - 12'h001;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prescale_r <= 4'h0;
		end else if (baudTick) begin
			prescale_r <= (prescale_r >= prescaleTop) ? 4'h0 : prescale_r + 4'h1;
		end
	end

	// Master clock runs at half the divider rate
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			xckInt_r <= 1'b0;
		end else if (syncMode && syncMaster && baudTick) begin
			xckInt_r <= ~xckInt_r;
		end
	end

	// Slave clock is asynchronous: two flops before the edge detector
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			xckS1_r <= 1'b0;
			xckS2_r <= 1'b0;
			xckS3_r <= 1'b0;
		end else begin
			xckS1_r <= xckPin;
			xckS2_r <= xckS1_r;
			xckS3_r <= xckS2_r;
		end
	end

	always_comb begin
		if (syncMaster) begin
			xckRise = baudTick && !xckInt_r && syncMode;
			xckFall = baudTick && xckInt_r && syncMode;
		end else begin
			xckRise = xckS2_r && !xckS3_r;
			xckFall = !xckS2_r && xckS3_r;
		end
	end

	assign xckOut       = xckInt_r;
	assign rxOvTick     = baudTick;
	assign txTick       = syncMode ? (clockPolarity ? xckFall : xckRise)
	                               : (baudTick && prescale_r >= prescaleTop);
	assign rxSampleEdge = clockPolarity ? xckRise : xckFall;

endmodule

// [usart_frame_tx.sv]
// Serial frame formatter, transmitter and frame receiver with an APB register file
`timescale 1ns/1ps
module usart_frame_tx (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rxdPin,
	input  wire logic        xckPin,
	output logic             txdOut,
	output logic             txdOe,
	output logic             xckOut,
	output logic             xckOe
);

	logic [7:0]              ctrlB_r;
	logic [7:0]              ctrlC_r;
	logic [11:0]             baudDivisor_r;
	logic [31:0]             prdata_r;
	logic                    pready_r;
	logic                    pslverr_r;
	logic [8:0]              bufData_r;
	logic                    bufFull_r;
	logic                    txComplete_r;
	logic                    txActive_r;
	logic                    txLine_r;
	logic                    xckOe_r;
	usart_pkg::txState_t     txState_r;
	logic [8:0]              txShift_r;
	logic                    txParity_r;
	logic [3:0]              txBitCnt_r;
	usart_pkg::rxState_t     rxState_r;
	logic [3:0]              rxCnt_r;
	logic [3:0]              rxBitCnt_r;
	logic [9:0]              rxShift_r;
	logic [8:0]              rxData_r;
	logic                    rxComplete_r;
	logic                    frameErr_r;
	logic                    rxdS1_r;
	logic                    rxdS2_r;

	logic                    access;
	logic                    wrEn;
	logic                    rdDone;
	logic                    mapped;
	logic                    dataWrite;
	logic                    baudWrite;
	logic                    fmtChange;
	logic                    txTick;
	logic                    rxOvTick;
	logic                    rxSampleEdge;
	logic                    xckGen;
	logic [2:0]              charSize;
	logic [3:0]              nBits;
	logic [8:0]              mask;
	logic [1:0]              parityMode;
	logic                    parityOn;
	logic                    twoStops;
	logic                    syncMode;
	logic                    txLastStop;
	logic                    txLoad;
	logic                    txDone;
	logic [8:0]              loadData;
	logic [3:0]              rxTarget;
	logic                    rxTick;
	logic [3:0]              rxFrameBits;
	logic [7:0]              statusRd;

	// One format setting is shared by both directions
	assign charSize   = {ctrlB_r[usart_pkg::CB_CSZ2], ctrlC_r[usart_pkg::CC_CSZ +: 2]};
	assign nBits      = usart_pkg::dataBits(charSize);
	assign mask       = usart_pkg::dataMask(nBits);
	assign parityMode = ctrlC_r[usart_pkg::CC_PAR +: 2];
	assign parityOn   = (parityMode == usart_pkg::PAR_EVEN) || (parityMode == usart_pkg::PAR_ODD);
	assign twoStops   = ctrlC_r[usart_pkg::CC_STOP];
	assign syncMode   = ctrlC_r[usart_pkg::CC_SYNC];

	// APB: one wait state, so read data and pready both come from flops
	assign access    = psel && penable && !pready_r;
	assign wrEn      = psel && penable && pready_r && pwrite;
	assign rdDone    = psel && penable && pready_r && !pwrite;
	assign mapped    = (paddr == usart_pkg::OFF_STATUS) || (paddr == usart_pkg::OFF_CTRL_B) ||
	                   (paddr == usart_pkg::OFF_CTRL_C) || (paddr == usart_pkg::OFF_DATA) ||
	                   (paddr == usart_pkg::OFF_BAUD);
	assign dataWrite = wrEn && (paddr == usart_pkg::OFF_DATA);
	assign baudWrite = wrEn && (paddr == usart_pkg::OFF_BAUD);
	assign fmtChange = wrEn && (((paddr == usart_pkg::OFF_CTRL_C) &&
	                   (pwdata[5:1] != ctrlC_r[5:1])) || ((paddr == usart_pkg::OFF_CTRL_B) &&
	                   (pwdata[usart_pkg::CB_CSZ2] != ctrlB_r[usart_pkg::CB_CSZ2])));

	assign statusRd = {rxComplete_r, txComplete_r, !bufFull_r, frameErr_r, 4'h0};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			pready_r  <= access;
			pslverr_r <= access && !mapped;
			if (access && !pwrite) begin
				unique case (paddr)
					usart_pkg::OFF_STATUS: prdata_r <= {24'h00_0000, statusRd};
					usart_pkg::OFF_CTRL_B: prdata_r <= {24'h00_0000, ctrlB_r[7:2],
					                                    rxData_r[8], ctrlB_r[0]};
					usart_pkg::OFF_CTRL_C: prdata_r <= {24'h00_0000, ctrlC_r};
					usart_pkg::OFF_DATA:   prdata_r <= {24'h00_0000, rxData_r[7:0]};
					usart_pkg::OFF_BAUD:   prdata_r <= {20'h0_0000, baudDivisor_r};
					default:               prdata_r <= 32'h0000_0000;
				endcase
			end else begin
				prdata_r <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrlB_r       <= usart_pkg::CTRL_B_RST;
			ctrlC_r       <= usart_pkg::CTRL_C_RST;
			baudDivisor_r <= usart_pkg::BAUD_RST;
		end else if (wrEn) begin
			if (paddr == usart_pkg::OFF_CTRL_B) begin
				ctrlB_r <= {2'h0, pwdata[5:2], 1'b0, pwdata[0]};
			end
			if (paddr == usart_pkg::OFF_CTRL_C) begin
				ctrlC_r <= pwdata[7:0];
			end
			if (baudWrite) begin
				baudDivisor_r <= pwdata[11:0];
			end
		end
	end

	usart_clock_gen clockGen (
		.clk           (clk),
		.reset_n       (reset_n),
		.baudDivisor   (baudDivisor_r),
		.baudReload    (baudWrite),
		.doubleSpeed   (ctrlB_r[usart_pkg::CB_U2X]),
		.syncMode      (syncMode),
		.syncMaster    (ctrlC_r[usart_pkg::CC_MAST]),
		.clockPolarity (ctrlC_r[usart_pkg::CC_POL]),
		.xckPin        (xckPin),
		.txTick        (txTick),
		.rxOvTick      (rxOvTick),
		.rxSampleEdge  (rxSampleEdge),
		.xckOut        (xckGen)
	);

	// Transmit buffer; ninth bit is taken from the control bit at write time
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bufData_r <= 9'h000;
			bufFull_r <= 1'b0;
		end else begin
			if (dataWrite) begin
				bufData_r <= {ctrlB_r[usart_pkg::CB_TXB8], pwdata[7:0]};
				bufFull_r <= 1'b1;
			end else if (txLoad) begin
				bufFull_r <= 1'b0;
			end
		end
	end

	// Pin ownership is held until the pending and shifting frames are gone
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			txActive_r <= 1'b0;
		end else if (ctrlB_r[usart_pkg::CB_TXEN]) begin
			txActive_r <= 1'b1;
		end else if (txState_r == usart_pkg::TX_IDLE && !bufFull_r) begin
			txActive_r <= 1'b0;
		end
	end

	assign txLastStop = (txState_r == usart_pkg::TX_STOP2) ||
	                    (txState_r == usart_pkg::TX_STOP1 && !twoStops);
	assign txLoad     = txTick && !fmtChange && bufFull_r && txActive_r &&
	                    (txState_r == usart_pkg::TX_IDLE || txLastStop);
	assign txDone     = txTick && !fmtChange && txLastStop && !txLoad;
	assign loadData   = bufData_r & mask;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			txState_r  <= usart_pkg::TX_IDLE;
			txLine_r   <= 1'b1;
			txShift_r  <= 9'h000;
			txParity_r <= 1'b0;
			txBitCnt_r <= 4'h0;
		end else if (fmtChange) begin
			txState_r <= usart_pkg::TX_IDLE;
			txLine_r  <= 1'b1;
		end else if (txLoad) begin
			txState_r  <= usart_pkg::TX_START;
			txLine_r   <= 1'b0;
			txShift_r  <= loadData;
			txParity_r <= (^loadData) ^ (parityMode == usart_pkg::PAR_ODD);
		end else if (txTick) begin
			unique case (txState_r)
				usart_pkg::TX_IDLE: begin
					txLine_r <= 1'b1;
				end
				usart_pkg::TX_START: begin
					txLine_r   <= txShift_r[0];
					txShift_r  <= txShift_r >> 1;
					txBitCnt_r <= 4'h1;
					txState_r  <= usart_pkg::TX_DATA;
				end
				usart_pkg::TX_DATA: begin
					if (txBitCnt_r == nBits) begin
						if (parityOn) begin
							txLine_r  <= txParity_r;
							txState_r <= usart_pkg::TX_PARITY;
						end else begin
							txLine_r  <= 1'b1;
							txState_r <= usart_pkg::TX_STOP1;
						end
					end else begin
						txLine_r   <= txShift_r[0];
						txShift_r  <= txShift_r >> 1;
						txBitCnt_r <= txBitCnt_r + 4'h1;
					end
				end
				usart_pkg::TX_PARITY: begin
					txLine_r  <= 1'b1;
					txState_r <= usart_pkg::TX_STOP1;
				end
				usart_pkg::TX_STOP1: begin
					txLine_r  <= 1'b1;
					txState_r <= twoStops ? usart_pkg::TX_STOP2 : usart_pkg::TX_IDLE;
				end
				usart_pkg::TX_STOP2: begin
					txLine_r  <= 1'b1;
					txState_r <= usart_pkg::TX_IDLE;
				end
				default: begin
					txLine_r  <= 1'b1;
					txState_r <= usart_pkg::TX_IDLE;
				end
			endcase
		end
	end

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			txComplete_r <= 1'b0;
		end else if (txDone) begin
			txComplete_r <= 1'b1;
		end else if (wrEn && paddr == usart_pkg::OFF_STATUS && pwdata[usart_pkg::ST_TXC]) begin
			txComplete_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			txdOe   <= 1'b0;
			xckOe_r <= 1'b0;
		end else begin
			txdOe   <= txActive_r;
			xckOe_r <= syncMode && ctrlC_r[usart_pkg::CC_MAST] &&
			           (txActive_r || ctrlB_r[usart_pkg::CB_RXEN]);
		end
	end

	// Receive pin is asynchronous to clk
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rxdS1_r <= 1'b1;
			rxdS2_r <= 1'b1;
		end else begin
			rxdS1_r <= rxdPin;
			rxdS2_r <= rxdS1_r;
		end
	end

	assign rxFrameBits = nBits + {3'h0, parityOn};
	assign rxTarget    = (rxState_r == usart_pkg::RX_START) ?
	                     (ctrlB_r[usart_pkg::CB_U2X] ? usart_pkg::HALF_DOUBLE : usart_pkg::HALF_NORMAL) :
	                     (ctrlB_r[usart_pkg::CB_U2X] ? usart_pkg::SPB_DOUBLE : usart_pkg::SPB_NORMAL);
	assign rxTick      = syncMode ? rxSampleEdge : (rxOvTick && rxCnt_r == rxTarget);

	// Oversample counter; mid-bit sampling in asynchronous mode only
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rxCnt_r <= 4'h0;
		end else if (rxState_r == usart_pkg::RX_IDLE || rxTick) begin
			rxCnt_r <= 4'h0;
		end else if (rxOvTick) begin
			rxCnt_r <= rxCnt_r + 4'h1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rxState_r  <= usart_pkg::RX_IDLE;
			rxBitCnt_r <= 4'h0;
			rxShift_r  <= 10'h000;
		end else if (fmtChange || !ctrlB_r[usart_pkg::CB_RXEN]) begin
			rxState_r <= usart_pkg::RX_IDLE;
		end else begin
			unique case (rxState_r)
				usart_pkg::RX_IDLE: begin
					rxBitCnt_r <= 4'h0;
					if (!rxdS2_r && (!syncMode || rxSampleEdge)) begin
						rxState_r <= syncMode ? usart_pkg::RX_BITS : usart_pkg::RX_START;
					end
				end
				usart_pkg::RX_START: begin
					if (rxTick) begin
						rxState_r <= rxdS2_r ? usart_pkg::RX_IDLE : usart_pkg::RX_BITS;
					end
				end
				usart_pkg::RX_BITS: begin
					if (rxTick) begin
						if (rxBitCnt_r == rxFrameBits) begin
							rxState_r <= usart_pkg::RX_IDLE;
						end else begin
							rxShift_r[rxBitCnt_r] <= rxdS2_r;
							rxBitCnt_r            <= rxBitCnt_r + 4'h1;
						end
					end
				end
				default: begin
					rxState_r <= usart_pkg::RX_IDLE;
				end
			endcase
		end
	end

	// First stop bit completes the frame; a second stop is not looked at
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rxData_r     <= 9'h000;
			frameErr_r   <= 1'b0;
			rxComplete_r <= 1'b0;
		end else if (rxState_r == usart_pkg::RX_BITS && rxTick && rxBitCnt_r == rxFrameBits &&
		             !fmtChange && ctrlB_r[usart_pkg::CB_RXEN]) begin
			rxData_r     <= rxShift_r[8:0] & mask;
			frameErr_r   <= !rxdS2_r;
			rxComplete_r <= 1'b1;
		end else if (rdDone && paddr == usart_pkg::OFF_DATA) begin
			rxComplete_r <= 1'b0;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign txdOut  = txLine_r;
	assign xckOut  = xckGen;
	assign xckOe   = xckOe_r;

endmodule

// [usart_frame_tx_chk.sv]
// Port-level assertions for the serial frame and transmit block
`timescale 1ns/1ps
module usart_frame_tx_chk (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        txdOut,
	input wire logic        txdOe,
	input wire logic        xckOut,
	input wire logic        xckOe
);
	logic [7:0]  shB_r;
	logic [7:0]  shC_r;
	logic [11:0] shBaud_r;
	logic [15:0] cnt_r;
	logic        txdPrev_r;
	logic        cntOk_r;
	logic        wrCfg;
	logic        edgeSeen;
	int          spb;

	assign wrCfg = psel && penable && pready && pwrite && !pslverr && paddr[3:0] != 4'hC
		&& paddr != usart_pkg::OFF_STATUS;
	assign edgeSeen = txdOut != txdPrev_r;
	assign spb = (int'(shBaud_r) + 1) * (shB_r[usart_pkg::CB_U2X] ? 8 : 16);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shB_r <= usart_pkg::CTRL_B_RST;
			shC_r <= usart_pkg::CTRL_C_RST;
			shBaud_r <= usart_pkg::BAUD_RST;
		end else if (wrCfg) begin
			if (paddr == usart_pkg::OFF_CTRL_B) shB_r <= pwdata[7:0];
			if (paddr == usart_pkg::OFF_CTRL_C) shC_r <= pwdata[7:0];
			if (paddr == usart_pkg::OFF_BAUD) shBaud_r <= pwdata[11:0];
		end
	end

	// A config write may re-time or abort a frame, so timing is trusted only after it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 16'h0000;
			txdPrev_r <= 1'b1;
			cntOk_r <= 1'b0;
		end else begin
			txdPrev_r <= txdOut;
			cnt_r <= edgeSeen ? 16'h0001 : cnt_r + 16'h0001;
			cntOk_r <= wrCfg ? 1'b0 : (edgeSeen | cntOk_r);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_pready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
	a_ready_delay: assert property (psel && penable && !$past(penable) |=> pready)
		else $error("ready not one cycle after access");
	a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error without ready or with data");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000) else $error("stray read data");
	a_line_idle: assert property (!txdOe |-> txdOut) else $error("released line not high");
	a_bit_period: assert property (edgeSeen && cntOk_r && txdOe && !shC_r[usart_pkg::CC_SYNC]
		|-> (int'(cnt_r) % spb) == 0) else $error("bit edge off the bit grid");
	a_release_idle: assert property ($fell(txdOe) && !shC_r[usart_pkg::CC_SYNC]
		|-> txdOut && int'(cnt_r) >= spb) else $error("pin released mid frame");
	a_sync_edge: assert property (edgeSeen && cntOk_r && txdOe && shC_r[usart_pkg::CC_SYNC]
		&& shC_r[usart_pkg::CC_MAST] |-> xckOut != shC_r[usart_pkg::CC_POL])
		else $error("data changed on sampling edge");
	a_clock_drive: assert property ($rose(xckOe) |-> shC_r[usart_pkg::CC_SYNC]
		&& shC_r[usart_pkg::CC_MAST]) else $error("clock pin driven outside master");

	c_err: cover property (pslverr);
	c_release: cover property ($fell(txdOe));
	c_master: cover property ($rose(xckOe));
endmodule

bind usart_frame_tx usart_frame_tx_chk i_usart_frame_tx_chk (.clk(clk), .reset_n(reset_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .txdOut(txdOut), .txdOe(txdOe),
	.xckOut(xckOut), .xckOe(xckOe));

// [usart_peer.sv]
// Remote serial peer: frame sampler, frame sender and slave transfer clock
`timescale 1ns/1ps
module usart_peer (
	input  wire logic txd,
	input  wire logic xckDev,
	output logic      rxd,
	output logic      transfer_clock_pin
);
	initial begin
		rxd = 1'b1;
		transfer_clock_pin = 1'b0;
	end

	// Slave clock runs only inside the frame it is asked for
	task automatic getFrame(input int spb, input bit sync, input bit mast, input bit pol,
		input int n, output logic [15:0] v, output time t);
		int i;
		v = 16'h0000;
		i = 0;
		transfer_clock_pin = pol;
		#7;
		if (!sync) begin
			@(negedge txd);
			t = $time;
			#(spb * 10);
			for (i = 0; i < n; i++) begin
				v[i] = txd;
				// Return at mid stop so a frame that follows at once is not missed
				if (i < n - 1) #(spb * 20);
			end
		end else begin
			while (i < n) begin
				if (mast) begin
					wait (xckDev == !pol);
					wait (xckDev == pol);
				end else begin
					#80 transfer_clock_pin = !pol;
					#80 transfer_clock_pin = pol;
				end
				if (i > 0 || txd == 1'b0) begin
					v[i] = txd;
					i++;
				end
			end
			t = $time;
			if (!mast) begin
				#80 transfer_clock_pin = !pol;
				#80 transfer_clock_pin = pol;
			end
		end
	endtask

	task automatic putFrame(input int spb, input int n, input logic [15:0] v);
		int i;
		for (i = 0; i < n; i++) begin
			rxd = v[i];
			#(spb * 20);
		end
		rxd = 1'b1;
	endtask
endmodule

// [tb_usart_frame_tx.sv]
// Self-checking bench for the serial frame and transmit block
`timescale 1ns/1ps
module tb_usart_frame_tx;
	logic        clk;
	logic        reset_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rxdPin;
	logic        txdOut;
	logic        txdOe;
	logic        xckOut;
	logic        xckOe;
	logic        peerXck;
	logic        xckPin;
	logic        txdLine;
	logic [31:0] r;
	logic        err;
	logic [15:0] v;
	logic [7:0]  rd;
	logic [2:0]  cszTab [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
	logic [1:0]  parTab [3] = '{2'h0, 2'h2, 2'h3};
	time         t0;
	time         t1;
	int          n_fail;
	int          compares;
	int          seed;
	int          f;
	int          k;

	assign xckPin = xckOe ? xckOut : peerXck;
	assign txdLine = txdOe ? txdOut : 1'b1;

	usart_frame_tx i_usart_frame_tx (.clk(clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxdPin(rxdPin), .xckPin(xckPin),
		.txdOut(txdOut), .txdOe(txdOe), .xckOut(xckOut), .xckOe(xckOe));
	usart_peer i_usart_peer (.txd(txdLine), .xckDev(xckOut), .rxd(rxdPin), .transfer_clock_pin(peerXck));

	task automatic summarize();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic cmpReg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmpFrame(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t frame got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (pready !== 1'b1) n_fail++;
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [15:0] expFrame(input int nb, input logic [1:0] par, input bit st,
		input logic [8:0] d);
		logic [15:0] x;
		logic        p;
		int          i;
		x = 16'h0000;
		p = par[0];
		for (i = 0; i < nb; i++) begin
			x[i + 1] = d[i];
			p = p ^ d[i];
		end
		i = nb + 1;
		if (par[1]) begin
			x[i] = p;
			i++;
		end
		x[i] = 1'b1;
		x[i + 1] = st;
		return x;
	endfunction

	task automatic txTest(input logic [2:0] csz, input logic [1:0] par, input bit st,
		input logic [8:0] d, input bit sync, input bit mast, input bit pol, input bit u,
		input int spb);
		int nb;
		int n;
		nb = (csz == 3'h7) ? 9 : int'(csz) + 5;
		apb(1, usart_pkg::OFF_CTRL_C, {24'h0000_00, mast, sync, par, st, csz[1:0], pol});
		apb(1, usart_pkg::OFF_CTRL_B, {26'h0, u, 2'h1, csz[2], 1'b0, d[8]});
		apb(1, usart_pkg::OFF_STATUS, 32'h0000_0040);
		apb(1, usart_pkg::OFF_DATA, {24'h0000_00, d[7:0]});
		i_usart_peer.getFrame(spb, sync, mast, pol, 2 + nb + par[1] + st, v, t0);
		cmpFrame(v, expFrame(nb, par, st, d));
		n = 0;
		do begin
			apb(0, usart_pkg::OFF_STATUS, 32'h0);
			n++;
		end while (r[6] !== 1'b1 && n < 200);
		cmpReg(r & 32'h0000_0060, 32'h0000_0060);
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		#1_500_000;
		n_fail++;
		summarize();
	end

	initial begin
		{reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
		seed = 77035;
		n_fail = 0;
		compares = 0;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		apb(0, usart_pkg::OFF_STATUS, 32'h0);
		cmpReg(r, 32'h0000_0020);
		apb(0, usart_pkg::OFF_CTRL_C, 32'h0);
		cmpReg(r, 32'h0000_0006);
		apb(0, 8'h14, 32'h0);
		cmpReg({r[31:1], err}, 32'h0000_0001);
		cmpReg({30'h0, txdOut, txdOe}, 32'h0000_0002);
		$display("reset test done");
		for (f = 0; f < 30; f++) txTest(cszTab[f % 5], parTab[(f / 5) % 3], f / 15,
			9'($random(seed)), 0, 0, 0, 0, 16);
		txTest(3'h3, 2'h2, 0, 9'($random(seed)), 0, 0, 0, 1, 8);
		apb(1, usart_pkg::OFF_BAUD, 32'h0000_0001);
		txTest(3'h3, 2'h3, 1, 9'($random(seed)), 0, 0, 0, 0, 32);
		apb(1, usart_pkg::OFF_BAUD, 32'h0000_0003);
		for (f = 0; f < 4; f++) txTest(f[1] ? 3'h7 : 3'h3, 2'h3, f[1], 9'($random(seed)),
			1, !f[1], f[0], 0, 0);
		apb(1, usart_pkg::OFF_BAUD, 32'h0);
		$display("format test done");
		apb(1, usart_pkg::OFF_CTRL_C, 32'h0000_0006);
		apb(1, usart_pkg::OFF_CTRL_B, 32'h0000_0008);
		fork
			begin
				i_usart_peer.getFrame(16, 0, 0, 0, 10, v, t0);
				cmpFrame(v, expFrame(8, 2'h0, 0, 9'h0A5));
				i_usart_peer.getFrame(16, 0, 0, 0, 10, v, t1);
				cmpFrame(v, expFrame(8, 2'h0, 0, 9'h03C));
			end
			begin
				apb(1, usart_pkg::OFF_DATA, 32'h0000_00A5);
				k = 0;
				do begin
					apb(0, usart_pkg::OFF_STATUS, 32'h0);
					k++;
				end while (r[5] !== 1'b1 && k < 30);
				apb(1, usart_pkg::OFF_DATA, 32'h0000_003C);
				apb(0, usart_pkg::OFF_STATUS, 32'h0);
				cmpReg(r & 32'h0000_0020, 32'h0);
			end
		join
		cmpReg(32'(t1 - t0), 32'h0000_0C80);
		apb(1, usart_pkg::OFF_DATA, 32'h0);
		repeat (48) @(posedge clk);
		apb(1, usart_pkg::OFF_CTRL_C, 32'h0000_0004);
		repeat (3) @(posedge clk);
		cmpReg({31'h0, txdOut}, 32'h0000_0001);
		repeat (300) @(posedge clk);
		cmpReg({31'h0, txdOut}, 32'h0000_0001);
		apb(1, usart_pkg::OFF_CTRL_C, 32'h0000_0006);
		fork
			begin
				i_usart_peer.getFrame(16, 0, 0, 0, 10, v, t0);
				cmpFrame(v, expFrame(8, 2'h0, 0, 9'h05A));
			end
			begin
				apb(1, usart_pkg::OFF_DATA, 32'h0000_005A);
				apb(1, usart_pkg::OFF_CTRL_B, 32'h0);
				cmpReg({31'h0, txdOe}, 32'h0000_0001);
			end
		join
		repeat (40) @(posedge clk);
		cmpReg({31'h0, txdOe}, 32'h0);
		$display("buffer test done");
		rd = 8'($random(seed));
		apb(1, usart_pkg::OFF_CTRL_B, 32'h0000_0010);
		apb(1, usart_pkg::OFF_CTRL_C, 32'h0000_000E);
		i_usart_peer.putFrame(16, 11, {5'h00, 2'h1, rd, 1'b0});
		apb(0, usart_pkg::OFF_STATUS, 32'h0);
		cmpReg(r & 32'h0000_0090, 32'h0000_0080);
		apb(0, usart_pkg::OFF_DATA, 32'h0);
		cmpReg(r, {24'h0000_00, rd});
		repeat (250) @(posedge clk);
		apb(0, usart_pkg::OFF_DATA, 32'h0);
		apb(1, usart_pkg::OFF_CTRL_C, 32'h0000_0006);
		i_usart_peer.putFrame(16, 10, {6'h00, 1'b0, rd, 1'b0});
		apb(0, usart_pkg::OFF_STATUS, 32'h0);
		cmpReg(r & 32'h0000_0090, 32'h0000_0090);
		$display("receive test done");
		summarize();
	end
endmodule
